// file: hdl/cbl_pkg.sv
// Shared constants and carriers for the configuration block loader host controller
package cbl_pkg;

	// ==========================================================
	// Software register map (AXI4-Lite byte offsets)
	localparam logic [7:0]  OFS_CMD      = 8'h00;
	localparam logic [7:0]  OFS_STATUS   = 8'h04;
	localparam logic [7:0]  OFS_DEVADDR  = 8'h08;
	localparam logic [6:0]  DEVADDR_RST  = 7'h65;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// Status word field positions
	localparam int ST_BUSY     = 0;
	localparam int ST_NACK     = 1;
	localparam int ST_REFUSED  = 2;
	localparam int ST_LOADING  = 3;
	localparam int ST_COMPLETE = 4;
	localparam int ST_COUNT_LO = 16;

	// ==========================================================
	// Device command indices on the serial link
	localparam logic [7:0]  DEV_REG_LOCK    = 8'h10;
	localparam logic [7:0]  DEV_REG_RESTART = 8'h11;
	localparam logic [7:0]  DEV_REG_ADDR    = 8'h12;
	localparam logic [7:0]  DEV_REG_WDATA   = 8'h14;

	// ==========================================================
	// Device values
	localparam logic [7:0]  LOCK_LOCKED   = 8'h00;
	localparam logic [7:0]  LOCK_UPDATING = 8'h01;
	localparam logic [7:0]  LOCK_UNLOCK   = 8'h02;
	localparam logic [7:0]  RESTART_VAL   = 8'h00;
	localparam logic [15:0] KEY_WORD      = 16'hbadc;
	localparam logic [15:0] CFG_BASE      = 16'he000;
	localparam logic [9:0]  CFG_BYTES     = 10'h200;
	localparam logic [9:0]  SEG_STEP      = 10'h002;
	localparam logic [15:0] LOG_ADDR_A    = 16'h1000;
	localparam logic [15:0] LOG_ADDR_B    = 16'h107e;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS  = 40;
	localparam int I2C_QUARTER_NS = 2500;
	localparam int QUARTER_CYC    = (I2C_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        two;
		logic [7:0]  reg_idx;
		logic [15:0] data;
	} cbl_cmd_t;

	typedef struct packed {
		logic [5:0] pad_hi;
		logic [9:0] count;
		logic [10:0] pad_lo;
		logic       complete;
		logic       loading;
		logic       refused;
		logic       nack;
		logic       busy;
	} cbl_status_t;

	typedef enum logic [2:0] {
		S_IDLE,
		S_START,
		S_BIT,
		S_ACK,
		S_STOP
	} cbl_state_t;

endpackage

// file: hdl/cbl_host.sv
// Host controller that loads configuration into the sequencer over its serial link
// ==========================================================
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module cbl_host #(
	parameter int QUARTER = cbl_pkg::QUARTER_CYC
) (
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	// AXI4-Lite write channels
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	// AXI4-Lite read channels
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// Open-drain serial link
	input  wire logic        SCL_I,
	output logic             SCL_O,
	output logic             SCL_OE_N,
	input  wire logic        SDA_I,
	output logic             SDA_O,
	output logic             SDA_OE_N
);

	// Below three cycles a quarter the synchronised line lags the ack sample
	if (QUARTER < 3 || QUARTER > 255) begin
		$error("QUARTER out of range");
	end

	function automatic logic [1:0] decode(input logic [7:0] a);
		if (a == cbl_pkg::OFS_CMD) begin
			return 2'h1;
		end else if (a == cbl_pkg::OFS_STATUS) begin
			return 2'h2;
		end else if (a == cbl_pkg::OFS_DEVADDR) begin
			return 2'h3;
		end else begin
			return 2'h0;
		end
	endfunction

	// ==========================================================
	// Bus slave
	logic        awready_reg, awready_next, bvalid_reg, bvalid_next;
	logic        arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [6:0]  devaddr_reg, devaddr_next;
	logic        wr_fire, rd_fire;
	logic [1:0]  wsel, rsel;
	cbl_pkg::cbl_status_t status;

	assign wr_fire = awready_reg && S_AXI_AWVALID && S_AXI_WVALID;
	assign rd_fire = arready_reg && S_AXI_ARVALID;
	assign wsel    = decode(S_AXI_AWADDR);
	assign rsel    = decode(S_AXI_ARADDR);

	always_comb begin
		awready_next = S_AXI_AWVALID && S_AXI_WVALID && !awready_reg && !bvalid_reg;
		bvalid_next  = wr_fire || (bvalid_reg && !S_AXI_BREADY);
		bresp_next   = bresp_reg;
		devaddr_next = devaddr_reg;
		if (wr_fire) begin
			bresp_next = (wsel == 2'h0) ? cbl_pkg::RESP_SLVERR : cbl_pkg::RESP_OKAY;
			if (wsel == 2'h3 && S_AXI_WSTRB[0]) begin
				devaddr_next = S_AXI_WDATA[6:0];
			end
		end
		arready_next = S_AXI_ARVALID && !arready_reg && !rvalid_reg;
		rvalid_next  = rd_fire || (rvalid_reg && !S_AXI_RREADY);
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		if (rd_fire) begin
			rresp_next = (rsel == 2'h0) ? cbl_pkg::RESP_SLVERR : cbl_pkg::RESP_OKAY;
			if (rsel == 2'h2) begin
				rdata_next = status;
			end else if (rsel == 2'h3) begin
				rdata_next = {25'h0000000, devaddr_reg};
			end else begin
				rdata_next = 32'h00000000;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			awready_reg <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= cbl_pkg::RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= cbl_pkg::RESP_OKAY;
			rdata_reg   <= 32'h00000000;
			devaddr_reg <= cbl_pkg::DEVADDR_RST;
		end else begin
			awready_reg <= awready_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
			devaddr_reg <= devaddr_next;
		end
	end

	// ==========================================================
	// Sequence guard: a host-side shadow of the device's update state
	cbl_pkg::cbl_cmd_t cmd, cmd_reg, cmd_next;
	logic [7:0]  lock_reg, lock_next;
	logic [15:0] exp_reg, exp_next, last_addr_reg, last_addr_next;
	logic [9:0]  count_reg, count_next;
	logic        loading_reg, loading_next, complete_reg, complete_next;
	logic        nack_reg, nack_next, refused_reg, refused_next;
	logic        cmd_fire, ok, launch, busy, nack_set;

	assign cmd      = cbl_pkg::cbl_cmd_t'(S_AXI_WDATA[24:0]);
	assign cmd_fire = wr_fire && wsel == 2'h1;
	assign launch   = cmd_fire && ok && !busy;

	always_comb begin
		ok = 1'b0;
		case (cmd.reg_idx)
			cbl_pkg::DEV_REG_LOCK: begin
				ok = !cmd.two && !(cmd.data[7:0] == cbl_pkg::LOCK_LOCKED
					&& loading_reg && !complete_reg);
			end
			cbl_pkg::DEV_REG_RESTART: begin
				ok = !cmd.two && lock_reg == cbl_pkg::LOCK_LOCKED
					&& cmd.data[7:0] == cbl_pkg::RESTART_VAL;
			end
			cbl_pkg::DEV_REG_ADDR: begin
				ok = cmd.two && (!loading_reg || cmd.data == exp_reg);
			end
			cbl_pkg::DEV_REG_WDATA: begin
				ok = cmd.two && lock_reg != cbl_pkg::LOCK_LOCKED
					&& (loading_reg ? !complete_reg : cmd.data == cbl_pkg::KEY_WORD);
			end
			default: begin
				ok = 1'b0;
			end
		endcase
	end

	always_comb begin
		cmd_next       = cmd_reg;
		lock_next      = lock_reg;
		exp_next       = exp_reg;
		last_addr_next = last_addr_reg;
		count_next     = count_reg;
		loading_next   = loading_reg;
		complete_next  = complete_reg;
		if (launch) begin
			cmd_next = cmd;
			if (cmd.reg_idx == cbl_pkg::DEV_REG_LOCK) begin
				lock_next = cmd.data[7:0];
				if (cmd.data[7:0] == cbl_pkg::LOCK_LOCKED) begin
					loading_next = 1'b0;
				end
			end else if (cmd.reg_idx == cbl_pkg::DEV_REG_ADDR) begin
				last_addr_next = cmd.data;
			end else if (cmd.reg_idx == cbl_pkg::DEV_REG_WDATA) begin
				if (!loading_reg && last_addr_reg == cbl_pkg::CFG_BASE) begin
					loading_next  = 1'b1;
					complete_next = 1'b0;
					exp_next      = cbl_pkg::CFG_BASE;
					count_next    = 10'h000;
				end else if (loading_reg) begin
					exp_next      = exp_reg + 16'(cbl_pkg::SEG_STEP);
					count_next    = count_reg + cbl_pkg::SEG_STEP;
					complete_next = count_reg + cbl_pkg::SEG_STEP == cbl_pkg::CFG_BYTES;
				end
			end
		end
		// A new event wins over a software clear in the same cycle
		nack_next    = nack_set || (nack_reg && !(wr_fire && wsel == 2'h2
			&& S_AXI_WDATA[cbl_pkg::ST_NACK]));
		refused_next = (cmd_fire && !launch) || (refused_reg && !(wr_fire && wsel == 2'h2
			&& S_AXI_WDATA[cbl_pkg::ST_REFUSED]));
	end

	always_comb begin
		status          = '0;
		status.busy     = busy;
		status.nack     = nack_reg;
		status.refused  = refused_reg;
		status.loading  = loading_reg;
		status.complete = complete_reg;
		status.count    = count_reg;
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			cmd_reg       <= '0;
			lock_reg      <= cbl_pkg::LOCK_LOCKED;
			exp_reg       <= cbl_pkg::CFG_BASE;
			last_addr_reg <= 16'h0000;
			count_reg     <= 10'h000;
			loading_reg   <= 1'b0;
			complete_reg  <= 1'b0;
			nack_reg      <= 1'b0;
			refused_reg   <= 1'b0;
		end else begin
			cmd_reg       <= cmd_next;
			lock_reg      <= lock_next;
			exp_reg       <= exp_next;
			last_addr_reg <= last_addr_next;
			count_reg     <= count_next;
			loading_reg   <= loading_next;
			complete_reg  <= complete_next;
			nack_reg      <= nack_next;
			refused_reg   <= refused_next;
		end
	end

	// ==========================================================
	// Serial link engine; write-only, since nothing is read back
	cbl_pkg::cbl_state_t st_reg, st_next;
	logic [7:0] div_reg, div_next, shift_reg, shift_next;
	logic [1:0] ph_reg, ph_next, byte_reg, byte_next;
	logic [2:0] bit_reg, bit_next;
	logic       scl_reg, scl_next, sda_reg, sda_next;
	logic       scl_s1, scl_s2, sda_s1, sda_s2, tick;
	logic [1:0] last_byte;

	assign busy      = st_reg != cbl_pkg::S_IDLE;
	assign tick      = busy && div_reg == 8'(QUARTER - 1) && !(ph_reg == 2'h3 && !scl_s2);
	assign last_byte = cmd_reg.two ? 2'h3 : 2'h2;
	assign nack_set  = tick && st_reg == cbl_pkg::S_ACK && ph_reg == 2'h2 && sda_s2;

	always_comb begin
		st_next    = st_reg;
		// Holds at the end of a quarter while a slave stretches the clock
		div_next   = (tick || !busy) ? 8'h00
			: (div_reg == 8'(QUARTER - 1)) ? div_reg : div_reg + 8'h01;
		ph_next    = ph_reg;
		bit_next   = bit_reg;
		byte_next  = byte_reg;
		shift_next = shift_reg;
		scl_next   = scl_reg;
		sda_next   = sda_reg;
		if (launch) begin
			st_next    = cbl_pkg::S_START;
			ph_next    = 2'h0;
			byte_next  = 2'h0;
			bit_next   = 3'h7;
			shift_next = {devaddr_reg, 1'b0};
		end else if (tick) begin
			ph_next = ph_reg + 2'h1;
			case (st_reg)
				cbl_pkg::S_START: begin
					sda_next = ph_reg == 2'h2 ? 1'b0 : sda_reg;
					if (ph_reg == 2'h3) begin
						st_next = cbl_pkg::S_BIT;
					end
				end
				cbl_pkg::S_BIT: begin
					// Data moves a quarter after the clock falls, never with it
					if (ph_reg == 2'h0) begin
						scl_next = 1'b0;
					end else if (ph_reg == 2'h1) begin
						sda_next = shift_reg[7];
					end else if (ph_reg == 2'h2) begin
						scl_next = 1'b1;
					end else if (ph_reg == 2'h3) begin
						shift_next = {shift_reg[6:0], 1'b0};
						bit_next   = bit_reg - 3'h1;
						if (bit_reg == 3'h0) begin
							st_next = cbl_pkg::S_ACK;
						end
					end
				end
				cbl_pkg::S_ACK: begin
					if (ph_reg == 2'h0) begin
						scl_next = 1'b0;
					end else if (ph_reg == 2'h1) begin
						sda_next = 1'b1;
					end else if (ph_reg == 2'h2) begin
						scl_next = 1'b1;
					end else if (ph_reg == 2'h3) begin
						byte_next = byte_reg + 2'h1;
						// Low byte of each pair goes first, so the device's auto-increment
						// lands the high byte in the partner register
						case (byte_reg)
							2'h0: shift_next = cmd_reg.reg_idx;
							2'h1: shift_next = cmd_reg.data[7:0];
							default: shift_next = cmd_reg.data[15:8];
						endcase
						// Judged from the line, so an uncleared old nack cannot cut a frame
						st_next = (sda_s2 || byte_reg == last_byte) ? cbl_pkg::S_STOP
							: cbl_pkg::S_BIT;
					end
				end
				cbl_pkg::S_STOP: begin
					if (ph_reg == 2'h0) begin
						scl_next = 1'b0;
					end else if (ph_reg == 2'h1) begin
						sda_next = 1'b0;
					end else if (ph_reg == 2'h2) begin
						scl_next = 1'b1;
					end else if (ph_reg == 2'h3) begin
						sda_next = 1'b1;
						st_next  = cbl_pkg::S_IDLE;
					end
				end
				default: begin
					st_next = cbl_pkg::S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			st_reg    <= cbl_pkg::S_IDLE;
			div_reg   <= 8'h00;
			ph_reg    <= 2'h0;
			bit_reg   <= 3'h7;
			byte_reg  <= 2'h0;
			shift_reg <= 8'h00;
			scl_reg   <= 1'b1;
			sda_reg   <= 1'b1;
			scl_s1    <= 1'b1;
			scl_s2    <= 1'b1;
			sda_s1    <= 1'b1;
			sda_s2    <= 1'b1;
		end else begin
			st_reg    <= st_next;
			div_reg   <= div_next;
			ph_reg    <= ph_next;
			bit_reg   <= bit_next;
			byte_reg  <= byte_next;
			shift_reg <= shift_next;
			scl_reg   <= scl_next;
			sda_reg   <= sda_next;
			scl_s1    <= SCL_I;
			scl_s2    <= scl_s1;
			sda_s1    <= SDA_I;
			sda_s2    <= sda_s1;
		end
	end

	// ==========================================================
	// Outputs; the pins only ever pull low, so the data outputs stay at zero
	assign S_AXI_AWREADY = awready_reg;
	assign S_AXI_WREADY  = awready_reg;
	assign S_AXI_BVALID  = bvalid_reg;
	assign S_AXI_BRESP   = bresp_reg;
	assign S_AXI_ARREADY = arready_reg;
	assign S_AXI_RVALID  = rvalid_reg;
	assign S_AXI_RRESP   = rresp_reg;
	assign S_AXI_RDATA   = rdata_reg;
	assign SCL_O         = 1'b0;
	assign SDA_O         = 1'b0;
	assign SCL_OE_N      = scl_reg;
	assign SDA_OE_N      = sda_reg;

	// ==========================================================
	// Checks
	property p_key_first;
		@(posedge CLOCK) disable iff (!RST_N)
		$rose(loading_reg) |-> $past(launch) && cmd_reg.data == cbl_pkg::KEY_WORD
			&& cmd_reg.reg_idx == cbl_pkg::DEV_REG_WDATA;
	endproperty
	a_key_first: assert property (p_key_first) else $error("load began without key");

	property p_early_lock;
		@(posedge CLOCK) disable iff (!RST_N)
		cmd_fire && cmd.reg_idx == cbl_pkg::DEV_REG_LOCK && !cmd.two
			&& cmd.data[7:0] == cbl_pkg::LOCK_LOCKED && loading_reg && !complete_reg
			|=> refused_reg && loading_reg;
	endproperty
	a_early_lock: assert property (p_early_lock) else $error("early lock not refused");

	property p_addr_order;
		@(posedge CLOCK) disable iff (!RST_N)
		cmd_fire && cmd.reg_idx == cbl_pkg::DEV_REG_ADDR && loading_reg
			&& cmd.data != exp_reg |=> refused_reg && $stable(last_addr_reg);
	endproperty
	a_addr_order: assert property (p_addr_order) else $error("out of order address sent");

	property p_seg_even;
		@(posedge CLOCK) disable iff (!RST_N)
		cmd_fire && cmd.reg_idx == cbl_pkg::DEV_REG_WDATA && !cmd.two |-> !launch ##1 refused_reg;
	endproperty
	a_seg_even: assert property (p_seg_even) else $error("odd data write sent");

	property p_count;
		@(posedge CLOCK) disable iff (!RST_N)
		complete_reg |-> count_reg == cbl_pkg::CFG_BYTES && exp_reg == cbl_pkg::CFG_BASE + 16'h0200;
	endproperty
	a_count: assert property (p_count) else $error("block size mismatch");

	property p_lock_shadow;
		@(posedge CLOCK) disable iff (!RST_N)
		launch && cmd.reg_idx == cbl_pkg::DEV_REG_LOCK |=> lock_reg == $past(cmd.data[7:0]) && busy;
	endproperty
	a_lock_shadow: assert property (p_lock_shadow) else $error("lock shadow stale");

	property p_restart_locked;
		@(posedge CLOCK) disable iff (!RST_N)
		$rose(busy) && cmd_reg.reg_idx == cbl_pkg::DEV_REG_RESTART
			|-> lock_reg == cbl_pkg::LOCK_LOCKED;
	endproperty
	a_restart_locked: assert property (p_restart_locked) else $error("restart while unlocked");

	property p_data_locked;
		@(posedge CLOCK) disable iff (!RST_N)
		cmd_fire && cmd.reg_idx == cbl_pkg::DEV_REG_WDATA && lock_reg == cbl_pkg::LOCK_LOCKED
			|=> refused_reg ##1 $stable(count_reg);
	endproperty
	a_data_locked: assert property (p_data_locked) else $error("data sent while locked");

endmodule

// file: test/cbl_dev_model.sv
// Behavioural model of the sequencer's configuration port on the serial link
`timescale 1ns/1ps
module cbl_dev_model #(
	parameter logic [6:0] DEV_ADDR = 7'h65
) (
	// Serial link, open drain with pull-ups
	input  wire logic scl,
	input  wire logic sda,
	output logic      sda_oe_n
);
	// ==========================================================
	// Frame capture
	logic [7:0]  sh = 8'h00;
	logic [7:0]  b [4];
	int          bitn = 0;
	int          nb = 0;
	logic        hit = 1'b0;
	logic [7:0]  lock = 8'h00;
	logic [15:0] addr = 16'h0000;
	logic [15:0] data = 16'h0000;
	logic [1:0]  clr = 2'b00;
	logic        persist = 1'b1;
	logic        monitoring = 1'b1;
	int          frames = 0;
	int          stores = 0;
	int          restarts = 0;

	initial sda_oe_n = 1'b1;

	// Start condition resets the byte counters
	always @(negedge sda) if (scl === 1'b1) begin
		bitn = 0;
		nb = 0;
		hit = 1'b0;
	end

	always @(posedge scl) if (bitn < 8) begin
		sh = {sh[6:0], sda};
		bitn = bitn + 1;
	end

	// Ack driven from the falling edge so it is settled long before the host samples it
	always @(negedge scl) begin
		if (bitn == 8) begin
			if (nb == 0) hit = (sh == {DEV_ADDR, 1'b0});
			if (hit && nb < 4) b[nb] = sh;
			sda_oe_n = !hit;
			bitn = 9;
		end else if (bitn == 9) begin
			sda_oe_n = 1'b1;
			nb = nb + 1;
			bitn = 0;
		end
	end

	// ==========================================================
	// Register effects, applied at the stop condition
	always @(posedge sda) if (scl === 1'b1 && hit && nb >= 3) begin
		frames = frames + 1;
		case (b[1])
			cbl_pkg::DEV_REG_LOCK: begin
				lock = b[2];
				// Rails go unwatched while memory is open for an update
				monitoring = (b[2] == cbl_pkg::LOCK_LOCKED);
			end
			cbl_pkg::DEV_REG_ADDR: addr = {b[3], b[2]};
			cbl_pkg::DEV_REG_WDATA: begin
				data = {b[3], b[2]};
				if (lock != cbl_pkg::LOCK_LOCKED) begin
					stores = stores + 1;
					if (data == cbl_pkg::KEY_WORD && addr == cbl_pkg::LOG_ADDR_A) clr[0] = 1'b1;
					if (data == cbl_pkg::KEY_WORD && addr == cbl_pkg::LOG_ADDR_B) clr[1] = 1'b1;
				end
			end
			cbl_pkg::DEV_REG_RESTART: if (b[2] == 8'h00) begin
				restarts = restarts + 1;
				if (clr == 2'b11) persist = 1'b0;
				clr = 2'b00;
			end
			default: ;
		endcase
	end
endmodule

// file: test/tb_cbl_host.sv
// Self-checking bench for the configuration loader host controller
`timescale 1ns/1ps
module tb_cbl_host;
	// ==========================================================
	// Signals
	logic        clk;
	logic        rst_n;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, st;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp, rr;
	logic        scl_o, scl_oe_n, sda_o, sda_oe_n, dev_oe_n;
	wire         scl = scl_oe_n ? 1'b1 : scl_o;
	wire         sda = (sda_oe_n ? 1'b1 : sda_o) & dev_oe_n;
	int          n_errors = 0;
	int          checked = 0;
	int          cycles = 0;

	cbl_host #(.QUARTER(4)) cbl_host_inst (
		.CLOCK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.SCL_I(scl), .SCL_O(scl_o), .SCL_OE_N(scl_oe_n),
		.SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n));

	cbl_dev_model dev_inst (.scl(scl), .sda(sda), .sda_oe_n(dev_oe_n));

	// ==========================================================
	// Shared tasks
	task automatic print_verdict();
		if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("BAD %0t got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic idle();
		do axr(cbl_pkg::OFS_STATUS, st, rr);
		while (st[cbl_pkg::ST_BUSY] !== 1'b0);
	endtask

	// One command, then the outcome on the link and in the status word
	task automatic send(input logic two, input logic [7:0] idx, input logic [15:0] d,
			input logic refd);
		int f;
		f = dev_inst.frames;
		axw(cbl_pkg::OFS_CMD, {7'h00, two, idx, d}, rr);
		idle();
		chk(32'(st[cbl_pkg::ST_REFUSED]), 32'(refd));
		chk(32'(dev_inst.frames - f), 32'(!refd));
		if (refd) axw(cbl_pkg::OFS_STATUS, 32'h0000_0004, rr);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		axr(cbl_pkg::OFS_DEVADDR, st, rr);
		chk(st, {25'h0, cbl_pkg::DEVADDR_RST});
		axr(cbl_pkg::OFS_STATUS, st, rr);
		chk(st, 32'h0);
		axr(8'h0c, st, rr);
		chk(32'(rr), 32'(cbl_pkg::RESP_SLVERR));
		axw(8'h0c, 32'h0, rr);
		chk(32'(rr), 32'(cbl_pkg::RESP_SLVERR));
		chk(32'({scl, sda}), 32'h3);
	endtask

	task automatic t_logclear();
		chk(32'(dev_inst.persist), 32'h1);
		send(1'b0, cbl_pkg::DEV_REG_LOCK, 16'h0002, 1'b0);
		chk(32'(dev_inst.monitoring), 32'h0);
		send(1'b1, cbl_pkg::DEV_REG_ADDR, 16'h1000, 1'b0);
		chk(32'(dev_inst.addr), 32'h1000);
		send(1'b1, cbl_pkg::DEV_REG_WDATA, 16'hbadc, 1'b0);
		chk(32'(dev_inst.data), 32'hbadc);
		send(1'b1, cbl_pkg::DEV_REG_ADDR, 16'h107e, 1'b0);
		send(1'b1, cbl_pkg::DEV_REG_WDATA, 16'hbadc, 1'b0);
		send(1'b0, cbl_pkg::DEV_REG_LOCK, 16'h0000, 1'b0);
		chk(32'(dev_inst.monitoring), 32'h1);
		send(1'b0, cbl_pkg::DEV_REG_RESTART, 16'h0000, 1'b0);
		chk(32'(dev_inst.restarts), 32'h1);
		chk(32'(dev_inst.persist), 32'h0);
	endtask

	task automatic t_guard();
		send(1'b1, cbl_pkg::DEV_REG_WDATA, 16'h1234, 1'b1);
		send(1'b0, 8'h33, 16'h0000, 1'b1);
		send(1'b0, cbl_pkg::DEV_REG_LOCK, 16'h0002, 1'b0);
		send(1'b0, cbl_pkg::DEV_REG_WDATA, 16'hbadc, 1'b1);
		send(1'b0, cbl_pkg::DEV_REG_RESTART, 16'h0000, 1'b1);
		send(1'b1, cbl_pkg::DEV_REG_WDATA, 16'h1234, 1'b1);
		// Second command lands while the first frame is still on the wire
		axw(cbl_pkg::OFS_CMD, 32'h0010_0002, rr);
		axw(cbl_pkg::OFS_CMD, 32'h0010_0002, rr);
		idle();
		chk(32'(st[cbl_pkg::ST_REFUSED]), 32'h1);
		axw(cbl_pkg::OFS_STATUS, 32'h0000_0004, rr);
	endtask

	task automatic t_nack();
		int f;
		f = dev_inst.frames;
		axw(cbl_pkg::OFS_DEVADDR, 32'h0000_0022, rr);
		axw(cbl_pkg::OFS_CMD, 32'h0010_0002, rr);
		idle();
		chk(32'(st[cbl_pkg::ST_NACK]), 32'h1);
		chk(32'(dev_inst.frames - f), 32'h0);
		axw(cbl_pkg::OFS_STATUS, 32'h0000_0002, rr);
		axr(cbl_pkg::OFS_STATUS, st, rr);
		chk(32'(st[cbl_pkg::ST_NACK]), 32'h0);
		axw(cbl_pkg::OFS_DEVADDR, 32'h0000_0065, rr);
	endtask

	task automatic t_load();
		int i;
		send(1'b1, cbl_pkg::DEV_REG_ADDR, 16'he000, 1'b0);
		send(1'b1, cbl_pkg::DEV_REG_WDATA, 16'hbadc, 1'b0);
		axr(cbl_pkg::OFS_STATUS, st, rr);
		chk(32'(st[cbl_pkg::ST_LOADING]), 32'h1);
		chk(32'(st[25:16]), 32'h0);
		send(1'b1, cbl_pkg::DEV_REG_ADDR, 16'he002, 1'b1);
		for (i = 0; i < 3; i++) begin
			send(1'b1, cbl_pkg::DEV_REG_WDATA, 16'(16'ha500 + i), 1'b0);
		end
		chk(32'(dev_inst.data), 32'ha502);
		axr(cbl_pkg::OFS_STATUS, st, rr);
		chk(32'(st[25:16]), 32'h6);
		send(1'b1, cbl_pkg::DEV_REG_ADDR, 16'he006, 1'b0);
		send(1'b0, cbl_pkg::DEV_REG_LOCK, 16'h0001, 1'b0);
		chk(32'(dev_inst.lock), 32'h1);
		send(1'b0, cbl_pkg::DEV_REG_LOCK, 16'h0000, 1'b1);
	endtask

	// ==========================================================
	// Clock, reset, sequence and hang guard
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Ceiling well above the seventeen frames of at most about 600 cycles each
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			n_errors++;
			print_verdict();
		end
	end

	initial begin
		rst_n = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_logclear();
		t_guard();
		t_nack();
		t_load();
		print_verdict();
	end
endmodule
